// ==== logic/dpwa_port_ctrl.v ====
// Purpose: Host-side write controller for one port of an asynchronous dual-port memory
// Assumes: Device pins are active low; data bus shared, device turns off on its own
// Notes:   One write or read-back at a time; collision pin sampled via two flops
`timescale 1ns/1ps
`default_nettype none
`include "dpwa_map.vh"
module dpwa_port_ctrl (
    // Clock and reset
    input  wire                    clk_i,
    input  wire                    resetn_i,
    // User request
    input  wire                    req_valid_i,
    output wire                    req_ready_o,
    input  wire                    req_write_i,
    input  wire                    req_flag_i,
    input  wire                    req_oe_low_i,
    input  wire [`DPWA_ADDR_W-1:0] req_addr_i,
    input  wire [`DPWA_DATA_W-1:0] req_wdata_i,
    // User answer
    output reg                     done_o,
    output reg                     blocked_o,
    output reg  [`DPWA_DATA_W-1:0] rdata_o,
    // Device pins
    output reg  [`DPWA_ADDR_W-1:0] addr_o,
    output reg                     select_n_o,
    output reg                     flag_select_n_o,
    output reg                     write_n_o,
    output reg                     oe_n_o,
    input  wire [`DPWA_DATA_W-1:0] data_i,
    output reg  [`DPWA_DATA_W-1:0] data_o,
    output reg                     data_oe_o,
    input  wire                    collision_n_i
);
    // One-hot states
    localparam [5:0] S_IDLE  = 6'h01;  // Pins idle, strobe and selects high
    localparam [5:0] S_STRB  = 6'h02;  // Strobe low first, selects still high
    localparam [5:0] S_WRITE = 6'h04;  // Overlap of select and strobe
    localparam [5:0] S_HOLD  = 6'h08;  // Extra hold after collision release
    localparam [5:0] S_READ  = 6'h10;  // Read-back with output enable low
    localparam [5:0] S_END   = 6'h20;  // Recovery, strobe and selects high

    reg  [5:0]              state;
    reg  [`DPWA_CNT_W-1:0]  cnt;          // Cycle counter for pulse widths
    reg                     saw_block;    // Collision seen during this write
    reg                     oe_low;       // Latched output-enable choice
    wire [`DPWA_DATA_W-1:0] data_s;       // Synchronised read data
    wire                    coll_s;       // Synchronised collision pin
    reg                     flag_req;     // Latched target: 1 = semaphore flag

    // Cycle counts, cut to the counter width on purpose
    localparam integer PULSE_INT    = `DPWA_PULSE_CYC;
    localparam integer PULSE_OE_INT = `DPWA_PULSE_OE_CYC;
    localparam integer HOLD_INT     = `DPWA_HOLD_CYC;
    localparam integer XPORT_INT    = `DPWA_XPORT_CYC;
    localparam [`DPWA_CNT_W-1:0] PULSE_CYC    = PULSE_INT[`DPWA_CNT_W-1:0];
    localparam [`DPWA_CNT_W-1:0] PULSE_OE_CYC = PULSE_OE_INT[`DPWA_CNT_W-1:0];
    localparam [`DPWA_CNT_W-1:0] HOLD_CYC     = HOLD_INT[`DPWA_CNT_W-1:0];
    localparam [`DPWA_CNT_W-1:0] XPORT_CYC    = XPORT_INT[`DPWA_CNT_W-1:0];
    // Read data passes two sync flops, so the capture waits for them too
    localparam [`DPWA_CNT_W-1:0] SYNC_LAT     = 4'h2;

    // Least pulse width, widened when the device may still drive
    function [`DPWA_CNT_W-1:0] pulse_len;
        input oel;
        begin
            pulse_len = oel ? PULSE_OE_CYC : PULSE_CYC;
        end
    endfunction

    dpwa_sync #(.W(`DPWA_DATA_W + 1)) u_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .async_i  ({collision_n_i, data_i}),
        .sync_o   ({coll_s, data_s})
    );

    // Accept only when pins are idle
    assign req_ready_o = (state == S_IDLE);

    // Sequencer; address moves only in idle, with strobe and selects high
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            state           <= S_IDLE;
            cnt             <= 4'h0;
            saw_block       <= 1'b0;
            oe_low          <= 1'b0;
            flag_req        <= 1'b0;
            done_o          <= 1'b0;
            blocked_o       <= 1'b0;
            rdata_o         <= 8'h00;
            addr_o          <= 15'h0000;
            select_n_o      <= 1'b1;
            flag_select_n_o <= 1'b1;
            write_n_o       <= 1'b1;
            oe_n_o          <= 1'b1;
            data_o          <= 8'h00;
            data_oe_o       <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (req_valid_i) begin
                        addr_o    <= req_addr_i;
                        data_o    <= req_wdata_i;
                        oe_low    <= req_oe_low_i;
                        flag_req  <= req_flag_i;                  // Request inputs may move after taking
                        saw_block <= 1'b0;
                        if (req_write_i) begin
                            // Strobe first so select falls after it: device stays off the bus
                            write_n_o <= 1'b0;
                            oe_n_o    <= ~req_oe_low_i;
                            state     <= S_STRB;
                        end else begin
                            // Wait port delay so the far side's write is visible
                            select_n_o      <= req_flag_i;
                            flag_select_n_o <= ~req_flag_i;
                            oe_n_o          <= 1'b0;
                            cnt             <= XPORT_CYC + SYNC_LAT;
                            state           <= S_READ;
                        end
                    end
                end
                S_STRB: begin
                    // Exactly one of the selects, held to end of write
                    select_n_o      <= flag_req ? 1'b1 : 1'b0;
                    flag_select_n_o <= flag_req ? 1'b0 : 1'b1;
                    // Drive data only once the device is known turned off
                    data_oe_o       <= 1'b1;
                    cnt             <= pulse_len(oe_low);
                    state           <= S_WRITE;
                end
                S_WRITE: begin
                    // Collision low inhibits the write; keep strobe until released
                    if (!coll_s) begin
                        saw_block <= 1'b1;
                    end else if (saw_block) begin
                        cnt   <= HOLD_CYC;
                        state <= S_HOLD;
                    end else if (cnt <= 4'h1) begin
                        // Output enable rises with the strobe: device must not drive into our data
                        write_n_o <= 1'b1;
                        oe_n_o    <= 1'b1;
                        state     <= S_END;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                S_HOLD: begin
                    if (!coll_s) begin
                        state <= S_WRITE;
                    end else if (cnt <= 4'h1) begin
                        write_n_o <= 1'b1;
                        oe_n_o    <= 1'b1;
                        blocked_o <= 1'b1;
                        state     <= S_END;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                S_READ: begin
                    if (cnt <= 4'h1) begin
                        rdata_o <= data_s;
                        state   <= S_END;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                default: begin
                    // Recovery: release everything, address still steady
                    select_n_o      <= 1'b1;
                    flag_select_n_o <= 1'b1;
                    write_n_o       <= 1'b1;
                    oe_n_o          <= 1'b1;
                    data_oe_o       <= 1'b0;
                    if (!select_n_o || !flag_select_n_o || data_oe_o) begin
                        state <= S_END;
                    end else begin
                        done_o <= 1'b1;
                        if (!saw_block) begin
                            blocked_o <= 1'b0;
                        end
                        state <= S_IDLE;
                    end
                end
            endcase
        end
    end
endmodule // dpwa_port_ctrl
`default_nettype wire

// ==== inc/dpwa_map.vh ====
// Purpose: Timing and field constants for the dual-port memory write controller
// Assumes: 10 MHz controller clock, 100 ns period
// Notes:   Times in ns; cycle counts derived from them
`ifndef DPWA_MAP_VH
`define DPWA_MAP_VH

`define DPWA_CLK_NS          100
// Write pulse width, least
`define DPWA_WRITE_PULSE_NS  40
// Output turn-off plus data set-up, least
`define DPWA_TURNOFF_NS      25
`define DPWA_DATA_SETUP_NS   30
// Write hold after the collision pin is released, least
`define DPWA_WRITE_HOLD_NS   25
// Port-to-port delay before the far side may read, longest wait
`define DPWA_PORT_DELAY_NS   80
// Semaphore write-to-read spacing, least
`define DPWA_SEM_W2R_NS      5

`define DPWA_CEIL(t)         (((t) + `DPWA_CLK_NS - 1) / `DPWA_CLK_NS)
`define DPWA_PULSE_CYC       `DPWA_CEIL(`DPWA_WRITE_PULSE_NS)
`define DPWA_PULSE_OE_CYC    `DPWA_CEIL(`DPWA_TURNOFF_NS + `DPWA_DATA_SETUP_NS)
`define DPWA_HOLD_CYC        `DPWA_CEIL(`DPWA_WRITE_HOLD_NS)
`define DPWA_XPORT_CYC       `DPWA_CEIL(`DPWA_PORT_DELAY_NS)
`define DPWA_SEM_CYC         `DPWA_CEIL(`DPWA_SEM_W2R_NS)

`define DPWA_ADDR_W          15
`define DPWA_DATA_W          8
`define DPWA_CNT_W           4

`endif

// ==== logic/dpwa_sync.v ====
// Purpose: Two-flop synchroniser for a bundle of asynchronous pins
// Assumes: Single controller clock
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module dpwa_sync #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         clk_i,
    input  wire         resetn_i,
    // Pins in, synchronised out
    input  wire [W-1:0] async_i,
    output reg  [W-1:0] sync_o
);
    reg [W-1:0] stage1;   // Metastability catcher

    // Two stages before any logic sees the pin
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            stage1 <= {W{1'b1}};
            sync_o <= {W{1'b1}};
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule // dpwa_sync
`default_nettype wire

// ==== tb/dpwa_dev_model.sv ====
// Purpose: Memory device on the far side of one port
// Assumes: Primary role; the bench steers the collision pin
// Notes:   An idle data bus shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module dpwa_dev_model (
    // Controller pins
    input  wire logic [14:0] addr_i,
    input  wire logic        sel_n_i,
    input  wire logic        flag_n_i,
    input  wire logic        wr_n_i,
    input  wire logic        oe_n_i,
    input  wire logic [7:0]  wdata_i,
    // Arbiter decision and device outputs
    input  wire logic        busy_n_i,
    output wire logic [7:0]  rdata_o,
    output wire logic        coll_n_o
);
    logic [7:0] mem [8];       // Low address bits only
    logic       flag = 1'b1;   // Semaphore starts free
    logic [7:0] last = 8'h00;  // Last driven value
    // Drive only outside a write
    wire drv = !oe_n_i && wr_n_i && !(sel_n_i && flag_n_i);
    // Cells shared with the other port
    wire [7:0] val = !sel_n_i ? mem[addr_i[2:0]] : {7'h7f, flag};
    // Collision pin follows the arbiter
    assign coll_n_o = busy_n_i;
    // Writes land while select and strobe overlap, dropped while busy
    always @* begin
        if (!wr_n_i && busy_n_i && !sel_n_i) mem[addr_i[2:0]] = wdata_i;
        if (!wr_n_i && busy_n_i && !flag_n_i) flag = wdata_i[0];
        if (drv) last = val;
    end
    assign rdata_o = drv ? val : ~last;
endmodule // dpwa_dev_model
`default_nettype wire

// ==== tb/dpwa_port_ctrl_chk.sv ====
// Purpose: Pin-order checks on the port controller
// Assumes: One clock domain
// Notes:   Collision pin passes two sync flops
`timescale 1ns/1ps
`default_nettype none
module dpwa_port_ctrl_chk (
    // Clock, reset and watched ports
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic [14:0] addr_o,
    input wire logic        select_n_o,
    input wire logic        flag_select_n_o,
    input wire logic        write_n_o,
    input wire logic        oe_n_o,
    input wire logic        data_oe_o,
    input wire logic        collision_n_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    wire sel = !select_n_o || !flag_select_n_o;  // A target selected
    chk_addr_quiet: assert property (
        !$stable(addr_o) |-> (write_n_o || select_n_o) && ($past(write_n_o) || $past(select_n_o)))
        else $error("Address moved inside a write");
    chk_no_fight: assert property (
        data_oe_o |-> !(sel && !oe_n_o && write_n_o)) else $error("Both sides drive data");
    chk_strobe_first: assert property (
        ($fell(select_n_o) || $fell(flag_select_n_o)) && data_oe_o |-> !$past(write_n_o))
        else $error("Select fell before strobe");
    chk_pulse_len: assert property (
        $rose(write_n_o) |-> $past(sel) && $past(data_oe_o)) else $error("Write pulse too short");
    chk_one_target: assert property (
        !(!select_n_o && !flag_select_n_o)) else $error("Both targets selected");
    chk_target_held: assert property (
        sel && !write_n_o |=> $stable(select_n_o) && $stable(flag_select_n_o))
        else $error("Target changed in a write");
    chk_wait_busy: assert property (
        (!collision_n_i && !write_n_o) [*3] |=> !write_n_o) else $error("Write ended while busy");
    chk_hold_after: assert property (
        $rose(collision_n_i) && !write_n_o |=> !write_n_o [*2]) else $error("No hold after busy");
    cover property (!collision_n_i && !write_n_o);
    cover property ($fell(flag_select_n_o));
    cover property (!oe_n_o && !write_n_o);
endmodule // dpwa_port_ctrl_chk
`default_nettype wire

// ==== tb/dual_port_write_arbitration_tb.sv ====
// Purpose: Self-checking bench for the port controller
// Assumes: Device model in primary role
// Notes:   Outputs sampled at the falling edge
`timescale 1ns/1ps
`default_nettype none
module dual_port_write_arbitration_tb;
    logic clk_i = 1'b0, resetn_i = 1'b0, req_valid = 1'b0, busy_n = 1'b1;
    logic req_write = 1'b0, req_flag = 1'b0, req_oe_low = 1'b0;
    logic [14:0] req_addr = 15'h0000, addr;
    logic [7:0] req_wdata = 8'h00, dq_in, dq_out, rdata;
    logic ready, done, blocked, sel_n, flag_n, wr_n, oe_n, dq_oe, coll_n;
    int n_fail = 0, samples_checked = 0;
    dpwa_port_ctrl u_dpwa_port_ctrl (.clk_i(clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid),
        .req_ready_o(ready), .req_write_i(req_write), .req_flag_i(req_flag), .req_oe_low_i(req_oe_low),
        .req_addr_i(req_addr), .req_wdata_i(req_wdata), .done_o(done), .blocked_o(blocked),
        .rdata_o(rdata), .addr_o(addr), .select_n_o(sel_n), .flag_select_n_o(flag_n), .write_n_o(wr_n),
        .oe_n_o(oe_n), .data_i(dq_in), .data_o(dq_out), .data_oe_o(dq_oe), .collision_n_i(coll_n));
    dpwa_dev_model u_dpwa_dev_model (.addr_i(addr), .sel_n_i(sel_n), .flag_n_i(flag_n), .wr_n_i(wr_n),
        .oe_n_i(oe_n), .wdata_i(dq_out), .busy_n_i(busy_n), .rdata_o(dq_in), .coll_n_o(coll_n));
    initial forever #50 clk_i = ~clk_i;
    task automatic check(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One transfer, waits for done under a bound
    task automatic xfer(input logic w, f, o, input logic [7:0] a, d);
        int n = 0;
        @(posedge clk_i);
        req_valid <= 1'b1;
        {req_write, req_flag, req_oe_low, req_addr, req_wdata} <= {w, f, o, 7'h00, a, d};
        @(posedge clk_i);
        req_valid <= 1'b0;
        do @(negedge clk_i); while (done !== 1'b1 && ++n < 40);
        check("done", done, 1'b1);
    endtask
    task automatic t_array;
        check("idle pins", {sel_n, flag_n, wr_n, oe_n, dq_oe}, 5'h1e);
        check("ready idle", ready, 1'b1);
        for (int i = 0; i < 4; i++) xfer(1'b1, 1'b0, i[0], i[7:0], 8'ha0 + i[7:0]);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, 1'b0, 1'b0, i[7:0], 8'h00);
            check("array read", rdata, 8'ha0 + i[7:0]);
        end
    endtask
    task automatic t_flag;
        xfer(1'b1, 1'b1, 1'b0, 8'h00, 8'hfe);
        xfer(1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
        check("flag read", rdata, 8'hfe);
        xfer(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
        check("array kept", rdata, 8'ha0);
    endtask
    // Collision low before the write, released mid-write
    task automatic t_busy;
        @(posedge clk_i);
        busy_n <= 1'b0;
        fork
            xfer(1'b1, 1'b0, 1'b0, 8'h01, 8'h5c);
            begin
                repeat (8) @(posedge clk_i);
                busy_n <= 1'b1;
            end
        join
        check("blocked", blocked, 1'b1);
        xfer(1'b0, 1'b0, 1'b0, 8'h01, 8'h00);
        check("late write", rdata, 8'h5c);
        xfer(1'b1, 1'b0, 1'b0, 8'h02, 8'h33);
        check("clean write", blocked, 1'b0);
    endtask
    task automatic end_of_test;
        if (n_fail == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(negedge clk_i);
        t_array();
        t_flag();
        t_busy();
        end_of_test();
    end
    initial begin
        repeat (2000) @(posedge clk_i);
        n_fail++;
        end_of_test();
    end
endmodule // dual_port_write_arbitration_tb
bind dpwa_port_ctrl dpwa_port_ctrl_chk u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .addr_o(addr_o),
    .select_n_o(select_n_o), .flag_select_n_o(flag_select_n_o), .write_n_o(write_n_o),
    .oe_n_o(oe_n_o), .data_oe_o(data_oe_o), .collision_n_i(collision_n_i));
`default_nettype wire
